// *** hdl/tfl_counter.sv ***
/*
  tfl_counter: 16-bit free-running counter advancing on each E tick,
  split into two 8-bit halves while timer test mode is on.
  Assumes tick is a one-cycle pulse in the hclk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module tfl_counter
  import tfl_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  tfl_cnt_if.cnt    c
);

  typedef struct packed {
    logic [15:0] count;
  } tfl_cnt_st_t;

  tfl_cnt_st_t st;
  tfl_cnt_st_t nx;

  always_comb begin
    nx = st;
    if (c.tick) begin
      if (c.test_dis) begin
        nx.count = 16'(st.count + 16'h0001);
      end else if (c.half_sel) begin
        nx.count[7:0] = 8'(st.count[7:0] + 8'h01);
      end else begin
        nx.count[15:8] = 8'(st.count[15:8] + 8'h01);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.count <= CNT_RST;
    end else begin
      st <= nx;
    end
  end

  assign c.count = st.count;

  ////////////////////////////////////////////////////////////////////////////

  property p_half_split;
    @(posedge hclk) disable iff (!hresetn)
    (c.tick && !c.test_dis) |=>
      // half select may be rewritten on the very tick edge, so use the one the tick saw
      ($past(c.half_sel) ? (c.count[15:8] == $past(c.count[15:8]))
                         : (c.count[7:0] == $past(c.count[7:0])));
  endproperty
  a_half_split: assert property (p_half_split) else $error("idle counter half moved");

  property p_full_count;
    @(posedge hclk) disable iff (!hresetn)
    (c.tick && c.test_dis) |=> (c.count == 16'($past(c.count) + 16'h0001));
  endproperty
  a_full_count: assert property (p_full_count) else $error("16-bit count step wrong");

endmodule : tfl_counter

`default_nettype wire

// *** hdl/tfl_timer.sv ***
/*
  tfl_timer: timer flags, interrupt enables, compare/capture registers and
  test split-counter control, reached over an AHB-Lite slave port.
  Assumes one master, single word transfers, data in the low byte.
*/
// Our own choice: register access over AHB-Lite.
// Behaviour
// - outside mode 0, bits 1:0 of the enable register read as ones
// - overflow enable gates the overflow flag onto the interrupt request
// - each compare enable gates its own compare flag onto the interrupt
// - each capture enable gates its own capture flag onto the interrupt
// - reset clears all six interrupt enables
// - test facility runs the counter as two separate 8-bit counters
// - with test on, half select picks upper (0) or lower (1) half
// - half select and test disable writable only in mode 0, reset to one
// - with test on, counter low byte reads transparently
// - test disable high gives a normal 16-bit counter
// - enable bits 7:2 behave the same in test mode
// - read-only 8-bit status register holds the six flags
// - overflow flag sets when the counter holds all ones
// - overflow flag clears on status read then counter high byte read
// - compare 1 flag sets on match, clears on status read then write
// - compare 2 flag sets on match, clears on status read then write
// - compare 3 flag sets on match, clears on status read then write
// - capture 1 flag sets on edge, clears on status read then high read
// - capture 2 flag sets on edge, clears on status read then high read
// - combined control/status register mirrors the same stored bits
`timescale 1ns/10ps
`default_nettype none

module tfl_timer
  import tfl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mode_zero,
  input  wire logic [1:0]  cap_pin,
  output logic             timer_interrupt_request
);

  typedef struct packed {
    logic [7:2]       en;
    logic [7:2]       flg;
    logic [7:2]       arm;
    logic [7:0]       tcr1;
    logic             test_dis;
    logic             half_sel;
    logic [2:0][15:0] cmp;
    logic [1:0][15:0] cap;
    logic [2:0]       inh;
    logic [7:0]       lo_buf;
    logic [1:0]       mode_s;
    logic [1:0][1:0]  cap_s;
    logic [1:0]       cap_d;
    logic [7:0]       ediv;
    logic             e_tick;
    logic             wr_pend;
    logic [7:0]       wr_idx;
    logic [31:0]      rdata;
    logic             rdy;
    logic             irq;
  } tfl_st_t;

  tfl_st_t     st;
  tfl_st_t     nx;
  logic [7:0]  rd;
  logic [7:0]  d;
  logic [7:0]  idx;
  logic        acc;
  logic        amap;
  logic [7:2]  ev_set;
  logic [7:2]  ev_trig;
  logic [7:2]  ev_clr;
  logic [1:0]  iedg;

  tfl_cnt_if cif ();

  tfl_counter u_counter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .c       (cif.cnt)
  );

  assign cif.tick     = st.e_tick;
  assign cif.test_dis = st.test_dis;
  assign cif.half_sel = st.half_sel;

  ////////////////////////////////////////////////////////////////////////////

  assign idx  = haddr[9:2];
  assign amap = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign acc  = hsel && hready && htrans[1] && amap;
  assign d    = hwdata[7:0];
  assign iedg = {st.tcr1[TCR1_IEDG2], st.tcr1[TCR1_IEDG1]};

  always_comb begin
    nx      = st;
    rd      = 8'h00;
    ev_set  = '0;
    ev_trig = '0;

    // two-flop synchronisers; only the second stage is used below
    nx.mode_s = {st.mode_s[0], mode_zero};
    for (int i = 0; i < 2; i++) begin
      nx.cap_s[i] = {st.cap_s[i][0], cap_pin[i]};
      nx.cap_d[i] = st.cap_s[i][1];
    end

    // E tick divider
    nx.e_tick = (st.ediv == E_DIV_LAST);
    nx.ediv   = nx.e_tick ? 8'h00 : 8'(st.ediv + 8'h01);

    // counter events, evaluated once per E period on the settled count
    if (st.e_tick) begin
      if (cif.count == CNT_ONES) begin
        ev_set[FLG_OVF] = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
        if (!st.inh[i] && (cif.count == st.cmp[i])) begin
          ev_set[FLG_OC1 + i] = 1'b1;
        end
      end
      nx.inh = '0;
    end

    // capture on the selected edge of the synchronised pin
    for (int i = 0; i < 2; i++) begin
      if ((st.cap_s[i][1] != st.cap_d[i]) && (st.cap_s[i][1] == iedg[i])) begin
        nx.cap[i]           = cif.count;
        ev_set[FLG_IC1 + i] = 1'b1;
      end
    end

    // write data phase
    if (st.wr_pend) begin
      case (st.wr_idx)
        IDX_CTLST: begin
          nx.en[FLG_IC1]         = d[4];
          nx.en[FLG_OC1]         = d[3];
          nx.en[FLG_OVF]         = d[2];
          nx.tcr1[TCR1_IEDG1]    = d[1];
          nx.tcr1[TCR1_OLVL1]    = d[0];
        end
        IDX_TCR1: begin
          nx.tcr1 = d;
        end
        IDX_IRQEN: begin
          nx.en = d[7:2];
          if (st.mode_s[1]) begin
            nx.test_dis = d[1];
            nx.half_sel = d[0];
          end
        end
        default: begin
        end
      endcase
      for (int i = 0; i < 3; i++) begin
        if (st.wr_idx == CMP_HI_IDX[i]) begin
          nx.cmp[i][15:8]      = d;
          nx.inh[i]            = 1'b1;
          ev_trig[FLG_OC1 + i] = 1'b1;
        end
        if (st.wr_idx == CMP_LO_IDX[i]) begin
          nx.cmp[i][7:0]       = d;
          ev_trig[FLG_OC1 + i] = 1'b1;
        end
      end
    end

    // read address phase; data sees a write completing in this cycle
    if (acc && !hwrite) begin
      case (idx)
        IDX_CTLST: begin
          rd = {st.flg[FLG_IC1], st.flg[FLG_OC1], st.flg[FLG_OVF],
                nx.en[FLG_IC1], nx.en[FLG_OC1], nx.en[FLG_OVF],
                nx.tcr1[TCR1_IEDG1], nx.tcr1[TCR1_OLVL1]};
          nx.arm[FLG_IC1] = st.arm[FLG_IC1] | st.flg[FLG_IC1];
          nx.arm[FLG_OC1] = st.arm[FLG_OC1] | st.flg[FLG_OC1];
          nx.arm[FLG_OVF] = st.arm[FLG_OVF] | st.flg[FLG_OVF];
        end
        IDX_CNT_HI: begin
          rd               = cif.count[15:8];
          nx.lo_buf        = cif.count[7:0];
          ev_trig[FLG_OVF] = 1'b1;
        end
        IDX_CNT_LO: begin
          rd = nx.test_dis ? st.lo_buf : cif.count[7:0];
        end
        IDX_TCR1: begin
          rd = nx.tcr1;
        end
        IDX_IRQEN: begin
          rd = {nx.en, st.mode_s[1] ? {nx.test_dis, nx.half_sel} : RO_ONES};
        end
        IDX_FLAGS: begin
          rd     = {st.flg, RO_ONES};
          nx.arm = st.arm | st.flg;
        end
        default: begin
        end
      endcase
      for (int i = 0; i < 3; i++) begin
        if (idx == CMP_HI_IDX[i]) begin
          rd = nx.cmp[i][15:8];
        end
        if (idx == CMP_LO_IDX[i]) begin
          rd = nx.cmp[i][7:0];
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (idx == CAP_HI_IDX[i]) begin
          rd                   = st.cap[i][15:8];
          ev_trig[FLG_IC1 + i] = 1'b1;
        end
        if (idx == CAP_LO_IDX[i]) begin
          rd = st.cap[i][7:0];
        end
      end
    end

    // a flag clears only after an armed status read; a new event wins
    ev_clr = st.arm & ev_trig;
    nx.flg = (st.flg & ~ev_clr) | ev_set;
    nx.arm = nx.arm & ~ev_trig;

    nx.wr_pend = acc && hwrite;
    nx.wr_idx  = idx;
    nx.rdata   = {24'h000000, rd};
    nx.rdy     = 1'b1;
    nx.irq     = |(nx.flg & nx.en);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= '0;
      st.tcr1     <= TCR1_RST;
      st.test_dis <= 1'b1;
      st.half_sel <= 1'b1;
      st.cmp      <= {3{CMP_RST}};
      st.rdy      <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign hrdata                  = st.rdata;
  assign hreadyout               = st.rdy;
  assign hresp                   = 1'b0;
  assign timer_interrupt_request = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ro_ones;
    (acc && !hwrite && idx == IDX_IRQEN && !st.mode_s[1]) |=> (hrdata[1:0] == 2'h3);
  endproperty
  a_ro_ones: assert property (p_ro_ones) else $error("low enable bits not ones");

  property p_irq_ovf;
    (st.flg[FLG_OVF] && st.en[FLG_OVF]) |-> timer_interrupt_request;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow interrupt missing");

  property p_irq_cmp;
    (|(st.flg[5:3] & st.en[5:3])) |-> timer_interrupt_request;
  endproperty
  a_irq_cmp: assert property (p_irq_cmp) else $error("compare interrupt missing");

  property p_irq_cap;
    (|(st.flg[7:6] & st.en[7:6])) |-> timer_interrupt_request;
  endproperty
  a_irq_cap: assert property (p_irq_cap) else $error("capture interrupt missing");

  property p_irq_quiet;
    !(|(st.flg & st.en)) |-> !timer_interrupt_request;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without enabled flag");

  property p_ovf_set;
    (st.e_tick && cif.count == CNT_ONES) |=> st.flg[FLG_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_test_lock;
    !st.mode_s[1] |=> ($stable(st.test_dis) && $stable(st.half_sel));
  endproperty
  a_test_lock: assert property (p_test_lock) else $error("test bits changed outside mode 0");

  property p_ovf_clr;
    (acc && !hwrite && idx == IDX_CNT_HI && st.arm[FLG_OVF] && !ev_set[FLG_OVF])
      |=> (!st.flg[FLG_OVF] && (hrdata[7:0] == $past(cif.count[15:8])));
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared");

  property p_cmp1_set;
    (st.e_tick && !st.inh[0] && cif.count == st.cmp[0]) |=> st.flg[FLG_OC1];
  endproperty
  a_cmp1_set: assert property (p_cmp1_set) else $error("compare 1 flag not set");

  property p_flags_ro;
    (st.wr_pend && st.wr_idx == IDX_FLAGS && ev_set == '0 && ev_clr == '0) |=> $stable(st.flg);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("status register was written");

endmodule : tfl_timer

`default_nettype wire

// *** shared/tfl_cnt_if.sv ***
/*
  tfl_cnt_if: carries E tick, test controls and the count between the
  register block and the free-running counter. Same hclk domain on both ends.
*/
`timescale 1ns/10ps
`default_nettype none

interface tfl_cnt_if;
  logic        tick;
  logic        test_dis;
  logic        half_sel;
  logic [15:0] count;

  modport ctl (output tick, output test_dis, output half_sel, input count);
  modport cnt (input tick, input test_dis, input half_sel, output count);
endinterface : tfl_cnt_if

`default_nettype wire

// *** shared/tfl_pkg.sv ***
/*
  tfl_pkg: register indices, field positions, reset values and timing
  constants of the timer flag, interrupt enable and test control block.
  Assumes a 100 MHz hclk; register byte address is four times the index.
*/
`default_nettype none

package tfl_pkg;

  // register indices, byte address = 4 * index
  localparam logic [7:0] IDX_CTLST   = 8'h08;
  localparam logic [7:0] IDX_CNT_HI  = 8'h09;
  localparam logic [7:0] IDX_CNT_LO  = 8'h0A;
  localparam logic [7:0] IDX_TCR1    = 8'h17;
  localparam logic [7:0] IDX_IRQEN   = 8'h18;
  localparam logic [7:0] IDX_FLAGS   = 8'h19;
  localparam logic [2:0][7:0] CMP_HI_IDX = {8'h1C, 8'h1A, 8'h0B};
  localparam logic [2:0][7:0] CMP_LO_IDX = {8'h1D, 8'h1B, 8'h0C};
  localparam logic [1:0][7:0] CAP_HI_IDX = {8'h1E, 8'h0D};
  localparam logic [1:0][7:0] CAP_LO_IDX = {8'h1F, 8'h0E};

  // flag and enable bit positions, shared by status and enable registers
  localparam int FLG_OVF = 2;
  localparam int FLG_OC1 = 3;
  localparam int FLG_IC1 = 6;
  localparam int FLG_IC2 = 7;

  // control register 1 fields
  localparam int TCR1_OLVL1 = 0;
  localparam int TCR1_IEDG1 = 3;
  localparam int TCR1_IEDG2 = 4;

  // values after reset, the all-ones overflow count and the read-only ones
  localparam logic [7:0]  TCR1_RST = 8'h20;
  localparam logic [15:0] CMP_RST  = 16'hFFFF;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_ONES = 16'hFFFF;
  localparam logic [1:0]  RO_ONES  = 2'h3;

  // E rate derived from the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int E_PERIOD_NS   = 40;
  localparam int E_DIV_CYCLES  = E_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0] E_DIV_LAST = 8'(E_DIV_CYCLES - 1);

endpackage : tfl_pkg

`default_nettype wire

// *** verif/tb.sv ***
/*
  tb: register-level tests of the timer flag and enable block.
  Assumes tfl_timer answers with zero wait states, byte in bits 7:0.
*/
`timescale 1ns/10ps
`default_nettype none

module tb
  import tfl_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        mode_zero;
  logic [1:0]  cap_pin;
  logic        timer_interrupt_request;
  int          n_errors;
  int          checks_done;
  int          cyc = 0;

  tfl_timer tfl_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .mode_zero(mode_zero),
    .cap_pin(cap_pin), .timer_interrupt_request(timer_interrupt_request));

  tfl_ahb_master tfl_ahb_master_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

  ////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk

  task rd(input logic [7:0] i, output logic [7:0] q);
    tfl_ahb_master_i.xfer(1'b0, {22'h0, i, 2'h0}, 8'h00, q);
  endtask : rd

  task wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    tfl_ahb_master_i.xfer(1'b1, {22'h0, i, 2'h0}, d, q);
  endtask : wr

  task ck_irq(input logic e);
    @(negedge hclk);
    chk("irq", {7'h0, timer_interrupt_request}, {7'h0, e});
  endtask : ck_irq

  ////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // hang guard, far above the longest overflow wait
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      $display("[FAIL] timeout expected %0d seen %0d", 40000, cyc);
      n_errors++;
      test_done;
    end
  end

  initial begin
    logic [7:0]  v;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] c;
    int          k;
    n_errors = 0;
    checks_done = 0;
    hresetn <= 1'b0;
    mode_zero <= 1'b0;
    cap_pin <= 2'h3;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;

    rd(IDX_IRQEN, v);
    chk("enables after reset", v, 8'h03);
    wr(IDX_IRQEN, 8'hFC);
    rd(IDX_IRQEN, v);
    chk("enables written", v, 8'hFF);
    wr(IDX_IRQEN, 8'h00);
    @(posedge hclk) mode_zero <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(IDX_IRQEN, v);
    chk("test bits kept", v, 8'h03);
    rd(IDX_FLAGS, v);
    chk("flags after reset", v, 8'h03);
    wr(IDX_FLAGS, 8'hFF);
    rd(IDX_FLAGS, v);
    chk("flags read only", v, 8'h03);
    tfl_ahb_master_i.xfer(1'b0, 32'h0000_0400, 8'h00, v);
    chk("unmapped", v, 8'h00);
    $display("test registers done");

    // split counter: low half runs, high half frozen, low read live
    wr(IDX_IRQEN, 8'h01);
    // two reads apart span six cycles, so at least one E tick lies between
    rd(IDX_CNT_LO, a);
    rd(IDX_CNT_LO, b);
    rd(IDX_CNT_LO, b);
    chk("low runs", {7'h0, a != b}, 8'h01);
    rd(IDX_CNT_HI, a);
    rd(IDX_CNT_HI, b);
    chk("high held", b, a);
    wr(IDX_IRQEN, 8'h00);
    rd(IDX_CNT_LO, a);
    rd(IDX_CNT_LO, b);
    chk("low held", b, a);
    v = 8'h00;
    for (k = 0; k < 600 && v !== 8'hF8; k++) rd(IDX_CNT_HI, v);
    chk("high runs", v, 8'hF8);
    wr(IDX_IRQEN, 8'h03);
    rd(IDX_IRQEN, v);
    chk("test off", v, 8'h03);
    rd(IDX_CNT_HI, v);
    rd(IDX_CNT_LO, a);
    rd(IDX_CNT_LO, b);
    chk("low latched", b, a);
    v = 8'h00;
    for (k = 0; k < 4000 && v[FLG_OVF] !== 1'b1; k++) rd(IDX_FLAGS, v);
    chk("overflow set", v & 8'h04, 8'h04);
    ck_irq(1'b0);
    wr(IDX_IRQEN, 8'h07);
    ck_irq(1'b1);
    rd(IDX_FLAGS, v);
    rd(IDX_CNT_HI, v);
    ck_irq(1'b0);
    rd(IDX_FLAGS, v);
    chk("overflow clear", v & 8'h04, 8'h00);
    @(posedge hclk) mode_zero <= 1'b0;
    $display("test counter done");

    // compares armed 256 ticks ahead of the live count
    wr(IDX_IRQEN, 8'h00);
    rd(IDX_CNT_HI, a);
    rd(IDX_CNT_LO, b);
    c = {a, b} + 16'h0100;
    for (k = 0; k < 3; k++) begin
      wr(CMP_HI_IDX[k], c[15:8]);
      wr(CMP_LO_IDX[k], c[7:0]);
    end
    v = 8'h00;
    for (k = 0; k < 600 && (v & 8'h38) !== 8'h38; k++) rd(IDX_FLAGS, v);
    chk("compare flags", v & 8'h38, 8'h38);
    for (k = 0; k < 3; k++) begin
      wr(IDX_IRQEN, 8'h08 << k);
      ck_irq(1'b1);
      rd(IDX_FLAGS, v);
      wr(CMP_LO_IDX[k], c[7:0]);
      ck_irq(1'b0);
    end
    $display("test compare done");

    // captures on falling edges, the edge bits being clear after reset
    wr(IDX_IRQEN, 8'h00);
    for (k = 0; k < 2; k++) begin
      @(posedge hclk) cap_pin[k] <= 1'b0;
      v = 8'h00;
      for (int j = 0; j < 10 && v[FLG_IC1 + k] !== 1'b1; j++) rd(IDX_FLAGS, v);
      chk("capture flag", v[FLG_IC1 + k], 1'b1);
      wr(IDX_IRQEN, 8'h40 << k);
      ck_irq(1'b1);
      if (k == 0) begin
        rd(IDX_CTLST, v);
        chk("combined view", v & 8'h90, 8'h90);
      end
      rd(IDX_FLAGS, v);
      rd(CAP_HI_IDX[k], v);
      ck_irq(1'b0);
    end
    $display("test capture done");
    test_done;
  end
endmodule : tb

`default_nettype wire

// *** verif/tfl_ahb_master.sv ***
/*
  tfl_ahb_master: single AHB-Lite master issuing single word transfers.
  Assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/10ps
`default_nettype none

module tfl_ahb_master (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   <= 1'b0;
    haddr  <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
  end

  ////////////////////////////////////////////////////////////
  // address phase held until hready, then data phase until hready
  task xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata[7:0];
    // stale write data must not look valid once the phase is over
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : tfl_ahb_master

`default_nettype wire
